// ===== tcc_pkg.sv
// constants, types and carrier structs for the timer channel clock core
// assumes one peripheral clock domain, all control arrives as plain ports
//
// What this block does
// - each channel has a 32-bit counter advancing on each selected clock edge
// - wrap from all-ones to zero sets the channel overflow flag
// - counter value output shows the live counter contents
// - trigger clears counter on the next valid selected clock edge
// - block mode routes each external clock from its pin or an io_line_a of its own module
// - clock select picks three external inputs or div 2, 8, 32, 128, slow
// - clock invert makes the channel count on the opposite edge
// - burst selects none or an external input as gate; count only while high
// - enable command enables channel clock, disable command disables it
// - capture mode: capture b load disables clock when disable_on_b_load set
// - waveform mode: compare c match disables clock when disable_on_c_compare set
// - while disabled, start and stop are ignored; only enable re-enables
// - clock enabled status follows the enabled state
// - any trigger starts the channel clock if enabled
// - capture b load or compare c match stops clock when stop bit set
// - start and stop act only while the clock is enabled
// - one block control write starts all channels of a module together
// - each channel drives its own interrupt output
// - six identical 32-bit channels in two modules of three
// - block sync bit acts as a software trigger on every channel of its module at once
// - mode bit: zero capture, one waveform, steering stop and disable events
package tcc_pkg;

    localparam int          NUM_CH        = 6;
    localparam int          CH_PER_MOD    = 3;
    localparam int          NUM_MOD       = 2;
    localparam int          CNT_W         = 32;
    localparam logic [31:0] CNT_RESET     = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX       = 32'hffff_ffff;
    localparam logic [6:0]  PRESC_RESET   = 7'h00;
    // prescaler bit whose rising transition marks a divided tick
    localparam int          DIV8_BIT      = 2;
    localparam int          DIV32_BIT     = 4;
    localparam int          DIV128_BIT    = 6;

    localparam logic [2:0]  CS_DIV2       = 3'h0;
    localparam logic [2:0]  CS_DIV8       = 3'h1;
    localparam logic [2:0]  CS_DIV32      = 3'h2;
    localparam logic [2:0]  CS_DIV128     = 3'h3;
    localparam logic [2:0]  CS_SLOW       = 3'h4;
    localparam logic [2:0]  CS_XC0        = 3'h5;
    localparam logic [2:0]  CS_XC1        = 3'h6;
    localparam logic [2:0]  CS_XC2        = 3'h7;

    localparam logic [1:0]  BURST_NONE    = 2'h0;

    typedef struct packed {
        logic [2:0] clock_source_select;
        logic       clock_invert;
        logic [1:0] burst_select;
        logic       wave_mode;
        logic       disable_on_b_load;
        logic       stop_on_b_load;
        logic       disable_on_c_compare;
        logic       stop_on_c_compare;
    } tcc_mode_s;

    typedef struct packed {
        logic clock_enable_cmd;
        logic clock_disable_cmd;
        logic software_trigger_cmd;
    } tcc_cmd_s;

    // clock run state: gray along off -> stopped -> running
    typedef enum logic [1:0] {
        TCC_OFF  = 2'b00,
        TCC_STOP = 2'b01,
        TCC_RUN  = 2'b11
    } tcc_run_e;

endpackage : tcc_pkg

// ===== tcc_core.sv
// six-channel counting core: clock routing, selection, gating and run control
// assumes commands are one-cycle pulses from same-clock logic, pins are async
`timescale 1ns/1ps
`default_nettype none
module tcc_core
    import tcc_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    input  wire logic [NUM_CH-1:0]            ext_clock_pin,
    input  wire logic [NUM_CH-1:0]            io_line_a,
    input  wire logic                         slow_clock,
    input  wire tcc_mode_s [NUM_CH-1:0]       channel_mode,
    input  wire tcc_cmd_s  [NUM_CH-1:0]       channel_cmd,
    input  wire logic [NUM_MOD-1:0]           block_sync_cmd,
    input  wire logic [NUM_MOD*6-1:0]         block_mode,
    input  wire logic [NUM_CH-1:0]            capture_b_load,
    input  wire logic [NUM_CH-1:0]            compare_c_match,
    input  wire logic [NUM_CH-1:0]            ext_trigger,
    input  wire logic [NUM_CH-1:0]            overflow_read_clear,
    output logic [NUM_CH-1:0][CNT_W-1:0]      counter_value,
    output logic [NUM_CH-1:0]                 counter_overflow_flag,
    output logic [NUM_CH-1:0]                 clock_enabled_status,
    output logic [NUM_CH-1:0]                 channel_irq
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // pins only; level rule on external clocks keeps edges resolvable
    logic [NUM_CH-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [NUM_CH-1:0] ioa_s1_reg, ioa_s2_reg, ioa_s3_reg;
    logic [2:0]        slow_s_reg;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            ioa_s1_reg <= '0;
            ioa_s2_reg <= '0;
            ioa_s3_reg <= '0;
            slow_s_reg <= '0;
        end
        else
        begin
            // stage 3 is a delayed copy left unused; edges are detected on the selected level
            pin_s1_reg <= ext_clock_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            ioa_s1_reg <= io_line_a;
            ioa_s2_reg <= ioa_s1_reg;
            ioa_s3_reg <= ioa_s2_reg;
            slow_s_reg <= {slow_s_reg[1:0], slow_clock};
        end
    end

    // ------------------------------------------------------------
    // prescaler for the internal divided ticks
    // ------------------------------------------------------------
    logic [6:0] presc_reg, presc_next;

    always_comb
    begin
        presc_next = presc_reg + 7'h01;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            presc_reg <= PRESC_RESET;
        else
            presc_reg <= presc_next;
    end

    // level of a divided clock: bit k of the prescaler is clock/2^(k+1)
    logic [4:0] int_level;
    logic [4:0] int_level_d;
    always_comb
    begin
        int_level = {slow_s_reg[1], presc_reg[DIV128_BIT], presc_reg[DIV32_BIT],
                     presc_reg[DIV8_BIT], presc_reg[0]};
        int_level_d = {slow_s_reg[2], presc_next[DIV128_BIT] ^ 1'b0, 3'b000};
    end

    // ------------------------------------------------------------
    // per-channel logic
    // ------------------------------------------------------------
    logic [NUM_CH-1:0]            lvl_d_reg, lvl_d_next;
    logic [NUM_CH-1:0]            trig_pend_reg, trig_pend_next;
    logic [NUM_CH-1:0]            ovf_reg, ovf_next;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_reg, cnt_next;
    tcc_run_e [NUM_CH-1:0]        run_reg, run_next;
    logic [NUM_CH-1:0]            irq_reg, irq_next;

    // route one channel's three external clock levels from the block mode field
    function automatic logic [2:0] route_xc(input int ch, input logic [NUM_CH*6-1:0] bm,
                                            input logic [NUM_CH-1:0] pins, input logic [NUM_CH-1:0] ioa);
        int  m;
        logic [2:0] r;
        m = ch / CH_PER_MOD;
        for (int k = 0; k < CH_PER_MOD; k++)
        begin
            // each input: pin of its own index, or line a of index (k + field) mod 3 in its module
            if (bm[m*6 + k*2 +: 2] == 2'h0)
                r[k] = pins[m*CH_PER_MOD + k];
            else
                r[k] = ioa[m*CH_PER_MOD + ((k + int'(bm[m*6 + k*2 +: 2])) % CH_PER_MOD)];
        end
        return r;
    endfunction : route_xc

    logic [NUM_MOD*6-1:0] bm_w;
    logic [NUM_CH*6-1:0]  bm_ext;
    always_comb
    begin
        bm_w   = block_mode;
        bm_ext = '0;
        bm_ext[NUM_MOD*6-1:0] = bm_w;
    end

    always_comb
    begin
        logic [2:0] xc;
        logic       sel;
        logic       gate;
        logic       edge_ok;
        logic       trig;
        logic       start_ev;
        logic       stop_ev;
        logic       dis_ev;
        int         mi;
        xc       = '0;
        sel      = 1'b0;
        gate     = 1'b1;
        edge_ok  = 1'b0;
        trig     = 1'b0;
        start_ev = 1'b0;
        stop_ev  = 1'b0;
        dis_ev   = 1'b0;
        mi       = 0;
        lvl_d_next     = lvl_d_reg;
        trig_pend_next = trig_pend_reg;
        ovf_next       = ovf_reg;
        cnt_next       = cnt_reg;
        run_next       = run_reg;
        irq_next       = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            mi = c / CH_PER_MOD;
            xc = route_xc(c, bm_ext, pin_s2_reg, ioa_s2_reg);
            case (channel_mode[c].clock_source_select)
                CS_DIV2:   sel = int_level[0];
                CS_DIV8:   sel = int_level[1];
                CS_DIV32:  sel = int_level[2];
                CS_DIV128: sel = int_level[3];
                CS_SLOW:   sel = int_level[4];
                CS_XC0:    sel = xc[0];
                CS_XC1:    sel = xc[1];
                CS_XC2:    sel = xc[2];
                default:   sel = int_level[0];
            endcase
            sel = sel ^ channel_mode[c].clock_invert;
            lvl_d_next[c] = sel;
            // gate from an external input, none means always open
            if (channel_mode[c].burst_select == BURST_NONE)
                gate = 1'b1;
            else
                gate = xc[channel_mode[c].burst_select - 2'h1];
            edge_ok = sel && !lvl_d_reg[c] && gate;
            // sync from block write hits all three channels at once
            trig = channel_cmd[c].software_trigger_cmd || block_sync_cmd[mi]
                   || ext_trigger[c] || (channel_mode[c].wave_mode && compare_c_match[c]);
            start_ev = trig;
            stop_ev = channel_mode[c].wave_mode ? (compare_c_match[c] && channel_mode[c].stop_on_c_compare)
                                                : (capture_b_load[c] && channel_mode[c].stop_on_b_load);
            dis_ev = channel_mode[c].wave_mode ? (compare_c_match[c] && channel_mode[c].disable_on_c_compare)
                                               : (capture_b_load[c] && channel_mode[c].disable_on_b_load);
            // run control: disable beats enable beats start/stop
            case (run_reg[c])
                TCC_OFF:
                    if (channel_cmd[c].clock_enable_cmd && !channel_cmd[c].clock_disable_cmd)
                        run_next[c] = TCC_STOP;
                TCC_STOP:
                    if (channel_cmd[c].clock_disable_cmd || dis_ev)
                        run_next[c] = TCC_OFF;
                    else if (start_ev)
                        run_next[c] = TCC_RUN;
                TCC_RUN:
                    // a compare match that also triggers must still stop when asked to
                    if (channel_cmd[c].clock_disable_cmd || dis_ev)
                        run_next[c] = TCC_OFF;
                    else if (stop_ev)
                        run_next[c] = TCC_STOP;
                default:
                    run_next[c] = TCC_OFF;
            endcase
            // trigger waits for the next valid selected edge
            if (trig && run_reg[c] != TCC_OFF)
                trig_pend_next[c] = 1'b1;
            if (edge_ok && run_reg[c] == TCC_RUN)
            begin
                if (trig_pend_reg[c])
                begin
                    cnt_next[c]       = CNT_RESET;
                    trig_pend_next[c] = trig && run_reg[c] != TCC_OFF;
                end
                else
                    cnt_next[c] = cnt_reg[c] + 32'h0000_0001;
            end
            // set wins over clear on the overflow flag
            if (overflow_read_clear[c])
                ovf_next[c] = 1'b0;
            if (edge_ok && run_reg[c] == TCC_RUN && !trig_pend_reg[c] && cnt_reg[c] == CNT_MAX)
            begin
                ovf_next[c] = 1'b1;
                irq_next[c] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // state registers, reset to a quiet channel
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl_d_reg     <= '0;
            trig_pend_reg <= '0;
            ovf_reg       <= '0;
            irq_reg       <= '0;
            for (int c = 0; c < NUM_CH; c++)
            begin
                cnt_reg[c] <= CNT_RESET;
                run_reg[c] <= TCC_OFF;
            end
        end
        else
        begin
            lvl_d_reg     <= lvl_d_next;
            trig_pend_reg <= trig_pend_next;
            ovf_reg       <= ovf_next;
            irq_reg       <= irq_next;
            cnt_reg       <= cnt_next;
            run_reg       <= run_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    always_comb
    begin
        counter_value         = cnt_reg;
        counter_overflow_flag = ovf_reg;
        channel_irq           = irq_reg;
        for (int c = 0; c < NUM_CH; c++)
            clock_enabled_status[c] = run_reg[c][0];
    end

    // six channels, two modules of three
    logic unused_ok;
    always_comb
    begin
        unused_ok = ^int_level_d ^ pin_s3_reg[0] ^ ioa_s3_reg[0];
    end

endmodule : tcc_core
`default_nettype wire

// ===== tcc_pin_model.sv
// far side model: external clock pins, io line a and slow clock levels
// assumes the bench starts and stops the clock frames through run
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model
(
    input  wire logic mclk,
    input  wire logic run,
    input  wire logic chain,
    input  wire logic gate,
    output logic [5:0] ext_clock_pin,
    output logic [5:0] io_line_a,
    output logic       slow_clock
);
    logic [1:0] ph  = 2'h0;
    logic       lvl = 1'b0;
    // each level lasts 3 cycles, a rate of mclk/6
    always @(posedge mclk)
    begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (run && ph == 2'h2)
            lvl <= ~lvl;
    end
    // unused route held low so a wrong chain selection stops counting
    assign ext_clock_pin = {4'h0, gate, lvl & ~chain};
    assign io_line_a     = {4'h0, lvl & chain, 1'b0};
    assign slow_clock    = ph[1];
endmodule : tcc_pin_model
`default_nettype wire

// ===== tcc_core_asserts.sv
// checker for the core, watching its ports only
// assumes one mclk domain with async active low nrst
`timescale 1ns/1ps
`default_nettype none
module tcc_core_asserts
    import tcc_pkg::*;
(
    input wire logic                    mclk,
    input wire logic                    nrst,
    input wire tcc_mode_s [NUM_CH-1:0]  channel_mode,
    input wire tcc_cmd_s [NUM_CH-1:0]   channel_cmd,
    input wire logic [NUM_CH-1:0]       capture_b_load,
    input wire logic [NUM_CH-1:0]       compare_c_match,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] counter_value,
    input wire logic [NUM_CH-1:0]       counter_overflow_flag,
    input wire logic [NUM_CH-1:0]       clock_enabled_status,
    input wire logic [NUM_CH-1:0]       channel_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        a_enable_sets_status: assert property (channel_cmd[i].clock_enable_cmd && !channel_cmd[i].clock_disable_cmd
            |=> clock_enabled_status[i]) else $error("status not set");
        a_disable_clears_status: assert property (channel_cmd[i].clock_disable_cmd
            |=> !clock_enabled_status[i]) else $error("status not cleared");
        a_rise_needs_enable: assert property ($rose(clock_enabled_status[i])
            |-> $past(channel_cmd[i].clock_enable_cmd)) else $error("enabled without command");
        a_fall_has_cause: assert property ($fell(clock_enabled_status[i]) |-> $past(channel_cmd[i].clock_disable_cmd
            || (capture_b_load[i] && !channel_mode[i].wave_mode && channel_mode[i].disable_on_b_load)
            || (compare_c_match[i] && channel_mode[i].wave_mode && channel_mode[i].disable_on_c_compare)))
            else $error("disabled without cause");
        a_frozen_when_off: assert property (!clock_enabled_status[i] [*2] |=> $stable(counter_value[i]))
            else $error("counter moved while disabled");
        a_count_step: assert property ($changed(counter_value[i]) |-> counter_value[i] == CNT_RESET
            || counter_value[i] == $past(counter_value[i]) + 32'h1) else $error("bad counter step");
        a_flag_on_wrap: assert property ($rose(counter_overflow_flag[i]) |-> $past(counter_value[i]) == CNT_MAX)
            else $error("overflow without wrap");
        a_irq_single: assert property (channel_irq[i] |=> !channel_irq[i])
            else $error("irq longer than one cycle");
        a_irq_with_flag: assert property (channel_irq[i] |-> counter_overflow_flag[i])
            else $error("irq without overflow");
    end
endmodule : tcc_core_asserts
bind tcc_core tcc_core_asserts chk_u (.mclk(mclk), .nrst(nrst), .channel_mode(channel_mode),
    .channel_cmd(channel_cmd), .capture_b_load(capture_b_load), .compare_c_match(compare_c_match),
    .counter_value(counter_value), .counter_overflow_flag(counter_overflow_flag),
    .clock_enabled_status(clock_enabled_status), .channel_irq(channel_irq));
`default_nettype wire

// ===== tcc_core_tb.sv
// testbench for the timer channel clock core
// assumes the pin model on the far side and a 250 MHz mclk
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb
    import tcc_pkg::*;
;
    logic                    mclk = 1'b0;
    logic                    nrst = 1'b0;
    tcc_mode_s [NUM_CH-1:0]  mode = '0;
    tcc_cmd_s  [NUM_CH-1:0]  cmd = '0;
    logic [1:0]              sync = '0;
    logic [11:0]             bmode = '0;
    logic [5:0]              bld = '0, ccm = '0, etrg = '0, ovc = '0;
    logic                    run = 1'b0, chain = 1'b0, gate = 1'b0;
    logic [5:0]              pin, ioa, ovf, sta, irq;
    logic                    slow;
    logic [NUM_CH-1:0][31:0] cv;
    int                      fails = 0, n_checks = 0, cyc = 0;
    int                      per [5] = '{2, 8, 32, 128, 3};
    tcc_core dut_u (.mclk(mclk), .nrst(nrst), .ext_clock_pin(pin), .io_line_a(ioa), .slow_clock(slow),
        .channel_mode(mode), .channel_cmd(cmd), .block_sync_cmd(sync), .block_mode(bmode),
        .capture_b_load(bld), .compare_c_match(ccm), .ext_trigger(etrg), .overflow_read_clear(ovc),
        .counter_value(cv), .counter_overflow_flag(ovf), .clock_enabled_status(sta), .channel_irq(irq));
    tcc_pin_model pin_u (.mclk(mclk), .run(run), .chain(chain), .gate(gate),
        .ext_clock_pin(pin), .io_line_a(ioa), .slow_clock(slow));
    initial
    begin
        forever #2 mclk = ~mclk;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic conclude();
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // hang guard, the sequence needs about 3200 cycles
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            conclude();
        end
    end
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic cmdp(int ch, tcc_cmd_s c);
        @(posedge mclk);
        cmd[ch] <= c;
        @(posedge mclk);
        cmd[ch] <= '0;
        #1;
    endtask : cmdp
    task automatic evt(logic [5:0] b, logic [5:0] c, logic [5:0] x, logic [1:0] s);
        @(posedge mclk);
        {bld, ccm, etrg, sync} <= {b, c, x, s};
        @(posedge mclk);
        {bld, ccm, etrg, sync} <= '0;
        #1;
    endtask : evt
    task automatic setm(int ch, tcc_mode_s m);
        @(posedge mclk);
        mode[ch] <= m;
        #1;
    endtask : setm
    // counts gained over span cycles
    task automatic rate(int ch, int span, logic [31:0] d);
        logic [31:0] a;
        a = cv[ch];
        tick(span);
        check(cv[ch] - a, d);
    endtask : rate
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        check({ovf, sta, irq, cv[0][13:0]}, 32'h0);
        cmdp(0, 3'b001);
        rate(0, 10, 0);
        cmdp(0, 3'b100);
        check(32'(sta), 32'h1);
        rate(0, 10, 0);
        cmdp(0, 3'b001);
        for (int s = 0; s < 5; s++)
        begin
            setm(0, {3'(s), 8'h00});
            tick(300);
            rate(0, per[s] * 4, 4);
        end
        setm(0, {CS_DIV128, 8'h00});
        tick(300);
        cmdp(0, 3'b001);
        check(32'(cv[0] != 0), 32'h1);
        tick(140);
        check(32'(cv[0] > 1), 32'h0);
        setm(0, {CS_DIV2, 3'h0, 1'b1, 4'h4});
        evt(6'h1, 6'h0, 6'h0, 2'h0);
        rate(0, 8, 4);
        setm(0, {CS_DIV2, 4'h0, 4'h4});
        evt(6'h1, 6'h0, 6'h0, 2'h0);
        tick(4);
        rate(0, 20, 0);
        check(32'(sta), 32'h1);
        cmdp(0, 3'b001);
        tick(4);
        rate(0, 8, 4);
        setm(0, {CS_DIV2, 3'h0, 1'b1, 4'h1});
        evt(6'h0, 6'h1, 6'h0, 2'h0);
        tick(4);
        rate(0, 20, 0);
        check(32'(sta), 32'h1);
        setm(0, {CS_DIV2, 4'h0, 4'h8});
        evt(6'h1, 6'h0, 6'h0, 2'h0);
        tick(1);
        check(32'(sta), 32'h0);
        cmdp(0, 3'b001);
        rate(0, 20, 0);
        cmdp(0, 3'b100);
        cmdp(0, 3'b001);
        setm(0, {CS_DIV2, 3'h0, 1'b1, 4'h2});
        evt(6'h0, 6'h1, 6'h0, 2'h0);
        tick(1);
        check(32'(sta), 32'h0);
        cmdp(0, 3'b100);
        cmdp(0, 3'b001);
        setm(0, '0);
        cmdp(0, 3'b010);
        tick(1);
        check(32'(sta), 32'h0);
        rate(0, 20, 0);
        cmdp(0, 3'b100);
        setm(0, {CS_XC0, 8'h00});
        run <= 1'b1;
        cmdp(0, 3'b001);
        tick(40);
        rate(0, 60, 10);
        bmode <= 12'h001;
        chain <= 1'b1;
        tick(40);
        rate(0, 60, 10);
        run <= 1'b0;
        tick(20);
        rate(0, 60, 0);
        bmode <= 12'h000;
        setm(0, {CS_DIV2, 1'b0, 2'h2, 5'h00});
        tick(10);
        rate(0, 20, 0);
        gate <= 1'b1;
        tick(10);
        rate(0, 20, 10);
        cmdp(2, 3'b100);
        cmdp(3, 3'b100);
        cmdp(4, 3'b100);
        evt(6'h0, 6'h0, 6'h0, 2'h2);
        tick(4);
        rate(3, 8, 4);
        rate(4, 8, 4);
        check(cv[2], 32'h0);
        cmdp(5, 3'b100);
        evt(6'h0, 6'h0, 6'h20, 2'h0);
        tick(4);
        rate(5, 8, 4);
        conclude();
    end
endmodule : tcc_core_tb
`default_nettype wire
